// ---- core/pin7_pkg.sv ----
// constants for the pin 7 output source multiplexer
package pin7_pkg;
    localparam logic [7:0] CTRL_ADDR       = 8'h17;  // pin7_output_control index
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam int         DRV_ON_BIT      = 0;
    localparam int         LOCAL_VAL_BIT   = 1;
    localparam int         SRC_LSB         = 2;
    localparam int         SEL_LSB         = 5;
    localparam int         NUM_RX          = 4;
    localparam int         NUM_TX          = 2;
    // source-select codes
    localparam logic [2:0] SRC_STATUS      = 3'h4;
    localparam logic [2:0] SRC_RESERVED    = 3'h5;
    localparam logic [2:0] SRC_TX0         = 3'h6;
    localparam logic [2:0] SRC_TX1         = 3'h7;
    // output-select codes for a receive port
    localparam logic [2:0] RX_REMOTE0      = 3'h0;
    localparam logic [2:0] RX_REMOTE2      = 3'h1;
    localparam logic [2:0] RX_UNDEF        = 3'h2;
    localparam logic [2:0] RX_REMOTE3      = 3'h3;
    localparam logic [2:0] RX_LOCK         = 3'h4;
    localparam logic [2:0] RX_PASS         = 3'h5;
    localparam logic [2:0] RX_FRAME        = 3'h6;
    localparam logic [2:0] RX_LINE         = 3'h7;
    // output-select codes for device status
    localparam logic [2:0] ST_LOCAL        = 3'h0;
    localparam logic [2:0] ST_LOCK_OR      = 3'h1;
    localparam logic [2:0] ST_LOCK_AND     = 3'h2;
    localparam logic [2:0] ST_PASS_AND     = 3'h3;
    // output-select codes for a transmit port
    localparam logic [2:0] TX_PASS_AND     = 3'h0;
    localparam logic [2:0] TX_PASS_OR      = 3'h1;
    localparam logic [2:0] TX_FRAME        = 3'h2;
    localparam logic [2:0] TX_LINE         = 3'h3;
    localparam logic [2:0] TX_SYNC         = 3'h4;
    localparam logic [2:0] TX_IRQ          = 3'h5;
endpackage : pin7_pkg

// ---- core/rx_port_pick.sv ----
// per receive port output-select decode
module rx_port_pick (
    input  wire logic [2:0] sel,
    input  wire logic [3:0] remotePins,
    input  wire logic       lock,
    input  wire logic       pass,
    input  wire logic       frameValid,
    input  wire logic       lineValid,
    output logic            pick
);
    // decode of the eight codes, undefined code gives low
    always_comb begin
        case (sel)
            pin7_pkg::RX_REMOTE0: pick = remotePins[0];  // RULE_02
            pin7_pkg::RX_REMOTE2: pick = remotePins[2];  // RULE_02
            pin7_pkg::RX_REMOTE3: pick = remotePins[3];  // RULE_02
            pin7_pkg::RX_LOCK:    pick = lock;           // RULE_03
            pin7_pkg::RX_PASS:    pick = pass;           // RULE_03
            pin7_pkg::RX_FRAME:   pick = frameValid;     // RULE_03
            pin7_pkg::RX_LINE:    pick = lineValid;      // RULE_03
            default:              pick = 1'b0;           // RULE_09
        endcase
    end
endmodule : rx_port_pick

// ---- core/pin7_output_source_mux.sv ----
// output source multiplexer and control register for general-purpose pin 7
//
// Contract
// RULE_01 - bits 4:2 pick receive, status or transmit
// RULE_02 - receive codes 000/001/011 pick remote pins
// RULE_03 - receive codes 100-111: lock, pass, frame, line
// RULE_04 - status codes: local value, lock OR/AND, pass AND
// RULE_05 - transmit codes: pass AND/OR, frame, line
// RULE_06 - transmit 100 synchronized, 101 interrupt, 111 reserved
// RULE_07 - bit 1 is the local pin level
// RULE_08 - bit 0 enables driver; all fields reset zero
// RULE_09 - reserved codes drive the pin low
//
// Chosen here: strobed register access.
module pin7_output_source_mux (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    output logic      [7:0] rdData,
    input  wire logic [3:0] rxRemotePins0,
    input  wire logic [3:0] rxRemotePins1,
    input  wire logic [3:0] rxRemotePins2,
    input  wire logic [3:0] rxRemotePins3,
    input  wire logic [3:0] rxLock,
    input  wire logic [3:0] rxPass,
    input  wire logic [3:0] rxFrameValid,
    input  wire logic [3:0] rxLineValid,
    input  wire logic [3:0] rxEnabled,
    input  wire logic [3:0] txPortSelect0,
    input  wire logic [3:0] txPortSelect1,
    input  wire logic [1:0] txFrameValid,
    input  wire logic [1:0] txLineValid,
    input  wire logic [1:0] txSynced,
    input  wire logic [1:0] txIrq,
    output logic            pinOut,
    output logic            pinOe
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic       pinOut_reg;
    logic       pinOut_next;
    logic       pinOe_reg;

    // field views of the control register
    wire logic [2:0] pin7SourceSelect = ctrl_reg[pin7_pkg::SRC_LSB +: 3];
    wire logic [2:0] pin7OutputSelect = ctrl_reg[pin7_pkg::SEL_LSB +: 3];
    wire logic       pin7LocalValue   = ctrl_reg[pin7_pkg::LOCAL_VAL_BIT];
    wire logic       pin7DriverOn     = ctrl_reg[pin7_pkg::DRV_ON_BIT];
    wire logic       ctrlHit          = (addr == pin7_pkg::CTRL_ADDR);

    // register write and read decode
    assign ctrl_next   = (wrStrobe && ctrlHit) ? wrData : ctrl_reg;
    assign rdData_next = (rdStrobe && ctrlHit) ? ctrl_reg : 8'h00;  // unmapped reads zero

    // one candidate per receive port
    logic [3:0] rxPick;
    rx_port_pick u_rx0 (
        .sel        (pin7OutputSelect),
        .remotePins (rxRemotePins0),
        .lock       (rxLock[0]),
        .pass       (rxPass[0]),
        .frameValid (rxFrameValid[0]),
        .lineValid  (rxLineValid[0]),
        .pick       (rxPick[0])
    );
    rx_port_pick u_rx1 (
        .sel        (pin7OutputSelect),
        .remotePins (rxRemotePins1),
        .lock       (rxLock[1]),
        .pass       (rxPass[1]),
        .frameValid (rxFrameValid[1]),
        .lineValid  (rxLineValid[1]),
        .pick       (rxPick[1])
    );
    rx_port_pick u_rx2 (
        .sel        (pin7OutputSelect),
        .remotePins (rxRemotePins2),
        .lock       (rxLock[2]),
        .pass       (rxPass[2]),
        .frameValid (rxFrameValid[2]),
        .lineValid  (rxLineValid[2]),
        .pick       (rxPick[2])
    );
    rx_port_pick u_rx3 (
        .sel        (pin7OutputSelect),
        .remotePins (rxRemotePins3),
        .lock       (rxLock[3]),
        .pass       (rxPass[3]),
        .frameValid (rxFrameValid[3]),
        .lineValid  (rxLineValid[3]),
        .pick       (rxPick[3])
    );

    // device status aggregates over enabled receive ports
    wire logic lockOr  = |(rxLock & rxEnabled);             // RULE_04
    wire logic lockAnd = &(rxLock | ~rxEnabled);            // RULE_04
    wire logic passAnd = &(rxPass | ~rxEnabled);            // RULE_04
    logic statusPick;
    always_comb begin
        case (pin7OutputSelect)
            pin7_pkg::ST_LOCAL:    statusPick = pin7LocalValue;  // RULE_07
            pin7_pkg::ST_LOCK_OR:  statusPick = lockOr;          // RULE_04
            pin7_pkg::ST_LOCK_AND: statusPick = lockAnd;         // RULE_04
            pin7_pkg::ST_PASS_AND: statusPick = passAnd;         // RULE_04
            default:               statusPick = 1'b0;            // RULE_09
        endcase
    end

    // transmit port candidate
    wire logic       txIdx    = (pin7SourceSelect == pin7_pkg::SRC_TX1);
    wire logic [3:0] txSel    = txIdx ? txPortSelect1 : txPortSelect0;
    wire logic       txPassA  = &(rxPass | ~txSel);          // RULE_05
    wire logic       txPassO  = |(rxPass & txSel);           // RULE_05
    logic txPick;
    always_comb begin
        case (pin7OutputSelect)
            pin7_pkg::TX_PASS_AND: txPick = txPassA;              // RULE_05
            pin7_pkg::TX_PASS_OR:  txPick = txPassO;              // RULE_05
            pin7_pkg::TX_FRAME:    txPick = txFrameValid[txIdx];  // RULE_05
            pin7_pkg::TX_LINE:     txPick = txLineValid[txIdx];   // RULE_05
            pin7_pkg::TX_SYNC:     txPick = txSynced[txIdx];      // RULE_06
            pin7_pkg::TX_IRQ:      txPick = txIrq[txIdx];         // RULE_06
            default:               txPick = 1'b0;                 // RULE_06 RULE_09
        endcase
    end

    // source selection
    always_comb begin
        case (pin7SourceSelect)
            3'h0, 3'h1, 3'h2, 3'h3: pinOut_next = rxPick[pin7SourceSelect[1:0]];  // RULE_01
            pin7_pkg::SRC_STATUS:   pinOut_next = statusPick;  // RULE_01
            pin7_pkg::SRC_TX0,
            pin7_pkg::SRC_TX1:      pinOut_next = txPick;      // RULE_01
            default:                pinOut_next = 1'b0;        // RULE_09
        endcase
    end

    // registers, all zero after reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg   <= pin7_pkg::CTRL_RESET;  // RULE_08
            rdData_reg <= 8'h00;
            pinOut_reg <= 1'b0;
            pinOe_reg  <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            rdData_reg <= rdData_next;
            pinOut_reg <= pinOut_next;
            pinOe_reg  <= pin7DriverOn;  // RULE_08
        end
    end

    assign rdData = rdData_reg;
    assign pinOut = pinOut_reg;
    assign pinOe  = pinOe_reg;

    // register, reset, driver enable and reserved source checks
    chk_reset_zero: assert property (@(posedge clk)  // RULE_08
        !nrst |=> ctrl_reg == 8'h00 && !pinOe)
        else $error("control not zero after reset");
    chk_pin_reset: assert property (@(posedge clk)  // RULE_08
        !nrst |=> !pinOut && rdData == 8'h00)
        else $error("pin or read data not zero after reset");
    chk_oe_follow: assert property (@(posedge clk) disable iff (!nrst)  // RULE_08
        $rose(pin7DriverOn) |=> pinOe)
        else $error("driver enable did not follow bit 0");
    chk_oe_drop: assert property (@(posedge clk) disable iff (!nrst)  // RULE_08
        $fell(pin7DriverOn) |=> !pinOe)
        else $error("driver enable did not drop with bit 0");
    chk_ctrl_write: assert property (@(posedge clk) disable iff (!nrst)  // RULE_07
        wrStrobe && ctrlHit |=> ctrl_reg == $past(wrData))
        else $error("control write not taken");
    chk_ctrl_hold: assert property (@(posedge clk) disable iff (!nrst)  // RULE_07
        !(wrStrobe && ctrlHit) |=> $stable(ctrl_reg))
        else $error("control changed without a write");
    chk_read_back: assert property (@(posedge clk) disable iff (!nrst)  // RULE_01
        rdStrobe && ctrlHit |=> rdData == $past(ctrl_reg))
        else $error("read data wrong");
    chk_src_rsvd: assert property (@(posedge clk) disable iff (!nrst)  // RULE_09
        pin7SourceSelect == pin7_pkg::SRC_RESERVED |=> !pinOut)
        else $error("reserved source not low");

    // receive port sources
    chk_rx_lock: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        pin7SourceSelect == 3'h2 && pin7OutputSelect == 3'h4 |=> pinOut == $past(rxLock[2]))
        else $error("rx lock not forwarded");
    chk_rx_remote: assert property (@(posedge clk) disable iff (!nrst)  // RULE_02
        pin7SourceSelect == 3'h1 && pin7OutputSelect == 3'h1
        |=> pinOut == $past(rxRemotePins1[2]))
        else $error("remote pin 2 not forwarded");
    chk_rx_remote0: assert property (@(posedge clk) disable iff (!nrst)  // RULE_02
        pin7SourceSelect == 3'h0 && pin7OutputSelect == pin7_pkg::RX_REMOTE0
        |=> pinOut == $past(rxRemotePins0[0]))
        else $error("remote pin 0 not forwarded");
    chk_rx_remote_p2: assert property (@(posedge clk) disable iff (!nrst)  // RULE_02
        pin7SourceSelect == 3'h2 && pin7OutputSelect == pin7_pkg::RX_REMOTE2
        |=> pinOut == $past(rxRemotePins2[2]))
        else $error("port 2 remote pin 2 not forwarded");
    chk_rx_remote3: assert property (@(posedge clk) disable iff (!nrst)  // RULE_02
        pin7SourceSelect == 3'h3 && pin7OutputSelect == pin7_pkg::RX_REMOTE3
        |=> pinOut == $past(rxRemotePins3[3]))
        else $error("remote pin 3 not forwarded");
    chk_rx_undef: assert property (@(posedge clk) disable iff (!nrst)  // RULE_02 RULE_09
        !pin7SourceSelect[2] && pin7OutputSelect == pin7_pkg::RX_UNDEF
        |=> !pinOut)
        else $error("undefined receive code not low");
    chk_rx_lock_any: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        !pin7SourceSelect[2] && pin7OutputSelect == pin7_pkg::RX_LOCK
        |=> pinOut == $past(rxLock[pin7SourceSelect[1:0]]))
        else $error("selected port lock not forwarded");
    chk_rx_pass: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        pin7SourceSelect == 3'h1 && pin7OutputSelect == pin7_pkg::RX_PASS
        |=> pinOut == $past(rxPass[1]))
        else $error("rx pass not forwarded");
    chk_rx_frame: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        pin7SourceSelect == 3'h0 && pin7OutputSelect == pin7_pkg::RX_FRAME
        |=> pinOut == $past(rxFrameValid[0]))
        else $error("rx frame valid not forwarded");
    chk_rx_frame3: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        pin7SourceSelect == 3'h3 && pin7OutputSelect == pin7_pkg::RX_FRAME
        |=> pinOut == $past(rxFrameValid[3]))
        else $error("port 3 frame valid not forwarded");
    chk_rx_line: assert property (@(posedge clk) disable iff (!nrst)  // RULE_03
        pin7SourceSelect == 3'h3 && pin7OutputSelect == pin7_pkg::RX_LINE
        |=> pinOut == $past(rxLineValid[3]))
        else $error("rx line valid not forwarded");

    // device status sources
    chk_local_val: assert property (@(posedge clk) disable iff (!nrst)  // RULE_07
        pin7SourceSelect == pin7_pkg::SRC_STATUS && pin7OutputSelect == 3'h0
        |=> pinOut == $past(pin7LocalValue))
        else $error("local value not presented");
    chk_lock_or: assert property (@(posedge clk) disable iff (!nrst)  // RULE_04
        pin7SourceSelect == 3'h4 && pin7OutputSelect == 3'h1
        |=> pinOut == $past(|(rxLock & rxEnabled)))
        else $error("lock OR wrong");
    chk_lock_and: assert property (@(posedge clk) disable iff (!nrst)  // RULE_04
        pin7SourceSelect == pin7_pkg::SRC_STATUS && pin7OutputSelect == pin7_pkg::ST_LOCK_AND
        |=> pinOut == $past(&(rxLock | ~rxEnabled)))
        else $error("lock AND wrong");
    chk_pass_and: assert property (@(posedge clk) disable iff (!nrst)  // RULE_04
        pin7SourceSelect == pin7_pkg::SRC_STATUS && pin7OutputSelect == pin7_pkg::ST_PASS_AND
        |=> pinOut == $past(&(rxPass | ~rxEnabled)))
        else $error("pass AND wrong");
    chk_status_rsvd: assert property (@(posedge clk) disable iff (!nrst)  // RULE_09
        pin7SourceSelect == pin7_pkg::SRC_STATUS && pin7OutputSelect[2]
        |=> !pinOut)
        else $error("unused status code not low");

    // transmit port sources
    chk_tx_irq: assert property (@(posedge clk) disable iff (!nrst)  // RULE_06
        pin7SourceSelect == 3'h7 && pin7OutputSelect == 3'h5 |=> pinOut == $past(txIrq[1]))
        else $error("tx interrupt not forwarded");
    chk_tx_irq0: assert property (@(posedge clk) disable iff (!nrst)  // RULE_06
        pin7SourceSelect == pin7_pkg::SRC_TX0 && pin7OutputSelect == pin7_pkg::TX_IRQ
        |=> pinOut == $past(txIrq[0]))
        else $error("tx 0 interrupt not forwarded");
    chk_tx_frame: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == 3'h6 && pin7OutputSelect == 3'h2
        |=> pinOut == $past(txFrameValid[0]))
        else $error("tx frame valid not forwarded");
    chk_tx_frame1: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == pin7_pkg::SRC_TX1 && pin7OutputSelect == pin7_pkg::TX_FRAME
        |=> pinOut == $past(txFrameValid[1]))
        else $error("tx 1 frame valid not forwarded");
    chk_tx_line: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == pin7_pkg::SRC_TX1 && pin7OutputSelect == pin7_pkg::TX_LINE
        |=> pinOut == $past(txLineValid[1]))
        else $error("tx 1 line valid not forwarded");
    chk_tx_line0: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == pin7_pkg::SRC_TX0 && pin7OutputSelect == pin7_pkg::TX_LINE
        |=> pinOut == $past(txLineValid[0]))
        else $error("tx 0 line valid not forwarded");
    chk_tx_pass_and: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == pin7_pkg::SRC_TX0 && pin7OutputSelect == pin7_pkg::TX_PASS_AND
        |=> pinOut == $past(&(rxPass | ~txPortSelect0)))
        else $error("tx pass AND wrong");
    chk_tx_pass_or: assert property (@(posedge clk) disable iff (!nrst)  // RULE_05
        pin7SourceSelect == pin7_pkg::SRC_TX1 && pin7OutputSelect == pin7_pkg::TX_PASS_OR
        |=> pinOut == $past(|(rxPass & txPortSelect1)))
        else $error("tx pass OR wrong");
    chk_tx_sync: assert property (@(posedge clk) disable iff (!nrst)  // RULE_06
        pin7SourceSelect == pin7_pkg::SRC_TX0 && pin7OutputSelect == pin7_pkg::TX_SYNC
        |=> pinOut == $past(txSynced[0]))
        else $error("tx 0 synchronized not forwarded");
    chk_tx_sync1: assert property (@(posedge clk) disable iff (!nrst)  // RULE_06
        pin7SourceSelect == pin7_pkg::SRC_TX1 && pin7OutputSelect == pin7_pkg::TX_SYNC
        |=> pinOut == $past(txSynced[1]))
        else $error("tx 1 synchronized not forwarded");
    chk_tx_rsvd: assert property (@(posedge clk) disable iff (!nrst)  // RULE_06 RULE_09
        pin7SourceSelect[2:1] == 2'b11 && pin7OutputSelect[2:1] == 2'b11
        |=> !pinOut)
        else $error("unused transmit code not low");

    // main scenarios reached
    cov_status: cover property (@(posedge clk) pin7SourceSelect == 3'h4 && pinOe);
    cov_tx1: cover property (@(posedge clk) pin7SourceSelect == 3'h7 && pinOut);
    cov_rx3: cover property (@(posedge clk) pin7SourceSelect == 3'h3 && pinOut);
    cov_tx0: cover property (@(posedge clk) pin7SourceSelect == 3'h6 && pinOut);
    cov_reserved: cover property (@(posedge clk) pin7SourceSelect == 3'h5 && pinOe);
endmodule : pin7_output_source_mux

// ---- test/pin7_board.sv ----
// board side of pin 7 with a pull-up resistor
module pin7_board (
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      boardLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven level while the driver is on, pull-up level otherwise
    assign boardLevel = pinOe ? pinOut : 1'b1;
endmodule : pin7_board

// ---- test/pin7_output_source_mux_tb_top.sv ----
// testbench for the pin 7 output source multiplexer
module pin7_output_source_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wrData = 8'h00;
    logic        wrStrobe = 1'b0;
    logic        rdStrobe = 1'b0;
    logic [7:0]  rdData;
    logic [51:0] stim = 52'h0;
    logic        pinOut, pinOe, boardLevel;
    logic [3:0]  rp0, rp1, rp2, rp3, lock, pass, fv, lv, en, ts0, ts1;
    logic [1:0]  tfv, tlv, tsy, tirq;
    int          fails = 0;
    int          n_compared = 0;
    logic [51:0] pats [4] = '{52'h0, {52{1'b1}}, 52'h5a3c69e1bd472, 52'ha5c3961e42b8d};
    // input patterns fan out from one word
    assign {tirq, tsy, tlv, tfv, ts1, ts0, en, lv, fv, pass, lock, rp3, rp2, rp1, rp0} = stim;
    always #12.5 clk = ~clk;
    pin7_output_source_mux DUT (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .rxRemotePins0(rp0),
        .rxRemotePins1(rp1), .rxRemotePins2(rp2), .rxRemotePins3(rp3), .rxLock(lock),
        .rxPass(pass), .rxFrameValid(fv), .rxLineValid(lv), .rxEnabled(en),
        .txPortSelect0(ts0), .txPortSelect1(ts1), .txFrameValid(tfv), .txLineValid(tlv),
        .txSynced(tsy), .txIrq(tirq), .pinOut(pinOut), .pinOe(pinOe));
    pin7_board board (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel));
    // expected pin level for a control value and an input pattern
    function automatic logic expPin(input logic [7:0] c, input logic [51:0] s);
        logic [3:0] ts;
        ts = c[2] ? s[43:40] : s[39:36];
        if (c[4] == 1'b0) begin
            case (c[7:5])
                3'h0: return s[4 * c[3:2]];
                3'h1: return s[4 * c[3:2] + 2];
                3'h3: return s[4 * c[3:2] + 3];
                3'h2: return 1'b0;
                default: return s[16 + 4 * (c[7:5] - 4) + c[3:2]];
            endcase
        end
        if (c[4:2] == 3'h5)
            return 1'b0;
        if (c[4:2] == 3'h4) begin
            case (c[7:5])
                3'h0: return c[1];
                3'h1: return |(s[19:16] & s[35:32]);
                3'h2: return &(s[19:16] | ~s[35:32]);
                3'h3: return &(s[23:20] | ~s[35:32]);
                default: return 1'b0;
            endcase
        end
        case (c[7:5])
            3'h0: return &(s[23:20] | ~ts);
            3'h1: return |(s[23:20] & ts);
            3'h2: return s[44 + c[2]];
            3'h3: return s[46 + c[2]];
            3'h4: return s[48 + c[2]];
            3'h5: return s[50 + c[2]];
            default: return 1'b0;
        endcase
    endfunction : expPin
    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
        end
    endtask : chkReg
    task automatic chkPin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t pin got %b expected %b", $time, got, exp);
        end
    endtask : chkPin
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        d = rdData;
    endtask : rd
    // program a control value and judge the pin under every input pattern
    task automatic tryCtrl(input logic [7:0] c);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            stim <= pats[i];
            wr(pin7_pkg::CTRL_ADDR, c);
            repeat (2) @(posedge clk);
            #1;
            chkPin(boardLevel, c[0] ? expPin(c, pats[i]) : 1'b1);
            chkPin(pinOe, c[0]);
        end
    endtask : tryCtrl
    task automatic testRegister();
        logic [7:0] d;
        rd(pin7_pkg::CTRL_ADDR, d);
        chkReg(d, pin7_pkg::CTRL_RESET);
        chkPin(pinOe, 1'b0);
        wr(8'h18, 8'hff);
        rd(pin7_pkg::CTRL_ADDR, d);
        chkReg(d, 8'h00);
        rd(8'h18, d);
        chkReg(d, 8'h00);
        wr(pin7_pkg::CTRL_ADDR, 8'ha6);
        rd(pin7_pkg::CTRL_ADDR, d);
        chkReg(d, 8'ha6);
        $display("testRegister done");
    endtask : testRegister
    task automatic testRx();
        for (int p = 0; p < 4; p++)
            for (int s = 0; s < 8; s++)
                tryCtrl({s[2:0], p[2:0], 2'b01});
        $display("testRx done");
    endtask : testRx
    task automatic testStatus();
        for (int s = 0; s < 16; s++)
            tryCtrl({s[3:1], pin7_pkg::SRC_STATUS, s[0], 1'b1});
        tryCtrl({pin7_pkg::ST_LOCAL, pin7_pkg::SRC_STATUS, 2'b10});
        $display("testStatus done");
    endtask : testStatus
    task automatic testTx();
        for (int s = 0; s < 16; s++)
            tryCtrl({s[2:0], 2'b11, s[3], 2'b11});
        for (int s = 0; s < 8; s++)
            tryCtrl({s[2:0], pin7_pkg::SRC_RESERVED, 2'b11});
        $display("testTx done");
    endtask : testTx
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        testRegister();
        testRx();
        testStatus();
        testTx();
        finish_test();
    end
endmodule : pin7_output_source_mux_tb_top
